// ---- hw/usb_out_endpoint_dma.sv ----
// Device end: two receive endpoints with registers and DMA control.
// Summary of operation
// (R1) Auto-clear drops packet-ready on the FIFO read of the last counted byte
// (R2) DMA mask gates endpoint A ready interrupt
// (R3) Toggle reset forces next PID DATA0
// (R4) STALL ending OUT sets stall-sent flag
// (R5) Oversize OUT packet is answered with STALL
// (R6) Stall request STALLs; clearing drops packet-ready
// (R7) Flush discards pending packet, self-clears
// (R8) Flush ignored without pending packet
// (R9) Full packet loaded sets packet-ready
// (R10) MCU clears packet-ready after reading packet
// (R11) Max packet code times eight, resets 0001
// (R12) Received byte count readable, seven bits
// (R13) MCU reads exactly the counted bytes
// (R14) FIFO data port, low byte only
// (R15) Mode select: interrupt or DMA
// (R16) DMA run bits start, stop, self-clear
// (R17) Demand mode enable bit
// (R18) Read-only TX run indicator, state field
// (R19) Transfer unit value, read by device
// (R20) RX DMA start loads FIFO byte counter
// (R21) MCU loads total counter before DMA
// (R22) Interrupt mode raises IRQ on ready
// (R23) Controls reset to zero, max code 0001
`timescale 1ns/100ps
`include "rx_ep_regs.svh"
module usb_out_endpoint_dma #(
    parameter int DEPTH = 64
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    usb_rx_link_if.device    link,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [31:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    output logic [1:0]       ep_irq_o,
    output logic             dma_req_o
);
    // ****************************************
    // Per-endpoint and DMA state
    // ****************************************
    logic [7:0] csr   [2];
    logic [3:0] max_packet_size  [2];
    logic [6:0] cnt   [2];
    logic       tog   [2];
    logic [6:0] rptr  [2];
    logic [7:0] mem   [2][DEPTH];
    logic [7:0] dctl;
    logic [7:0] unit_val;
    logic [7:0] dma_fifo_byte_counter;
    logic [7:0] unit_left;
    rx_ep_pkg::dma_state_t dstate;

    logic       cur_ep;
    logic       in_pkt;
    logic       bad;
    logic [6:0] wcnt;

    function automatic logic [6:0] max_packet_size_bytes(input logic [3:0] code);
        max_packet_size_bytes = 7'(code * `MAX_PACKET_SIZE_STEP); // R11
    endfunction

    // ****************************************
    // Bus decode
    // ****************************************
    wire        req    = cyc_i && stb_i && !ack_o;
    wire        wr     = req && we_i && sel_i[0];
    wire        rd     = req && !we_i;
    wire        hit_c0 = adr_i == `EPA_CSR_OFF;
    wire        hit_c1 = adr_i == `EPB_CSR_OFF;
    wire        hit_m0 = adr_i == `EPA_MAX_PACKET_SIZE_OFF;
    wire        hit_m1 = adr_i == `EPB_MAX_PACKET_SIZE_OFF;
    wire        hit_f0 = adr_i == `EPA_FIFO_OFF;
    wire        hit_f1 = adr_i == `EPB_FIFO_OFF;
    wire        hit_dc = adr_i == `DMA_CTRL_OFF;
    wire        hit_du = adr_i == `DMA_UNIT_OFF;
    wire        hit_fc = adr_i == `DMA_FCNT_OFF;
    wire [1:0]  fifo_rd = {rd && hit_f1, rd && hit_f0};
    wire [1:0]  csr_wr  = {wr && hit_c1, wr && hit_c0};
    wire        rx_run_set = wr && hit_dc && dat_i[`BIT_RX_DMA_RUN]
                             && !dctl[`BIT_RX_DMA_RUN];
    wire        dma_mode   = dctl[`BIT_DMA_MODE]; // R15
    wire        tok_stall  = csr[link.tok_ep][`BIT_SEND_STALL];
    wire        pid_ok     = link.dat_pid1 == tog[cur_ep];
    wire [6:0]  lim        = max_packet_size_bytes(max_packet_size[cur_ep]);
    wire        over       = link.dat_valid && (wcnt >= lim); // R5
    wire        busy_rx    = csr[cur_ep][`BIT_PKT_RDY];
    // The last byte arrives with the end marker, so it is counted here.
    wire        take       = in_pkt && link.dat_valid && !over
                             && wcnt < 7'(DEPTH);
    wire [6:0]  rx_len     = wcnt + 7'(take); // R12

    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0000_0000;
        if (hit_c0) rdata = {24'h00_0000, csr[0]};
        else if (hit_c1) rdata = {24'h00_0000, csr[1]};
        else if (hit_m0) rdata = {28'h000_0000, max_packet_size[0]};
        else if (hit_m1) rdata = {28'h000_0000, max_packet_size[1]};
        else if (adr_i == `EPA_CNT_OFF) rdata = {25'h0, cnt[0]}; // R12
        else if (adr_i == `EPB_CNT_OFF) rdata = {25'h0, cnt[1]};
        else if (hit_f0) rdata = {24'h00_0000, mem[0][6'(rptr[0])]}; // R14
        else if (hit_f1) rdata = {24'h00_0000, mem[1][6'(rptr[1])]};
        else if (hit_dc) rdata = {24'h00_0000, dctl};
        else if (hit_du) rdata = {24'h00_0000, unit_val};
        else if (hit_fc) rdata = {24'h00_0000, dma_fifo_byte_counter};
    end

    // ****************************************
    // Bus slave: one wait-state ack, unmapped reads return zero.
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req;
            dat_o <= rdata;
        end
    end

    // ****************************************
    // Link receive
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_ep        <= 1'b0;
            in_pkt        <= 1'b0;
            bad           <= 1'b0;
            wcnt          <= 7'h00;
            link.hs_valid <= 1'b0;
            link.hs_code  <= rx_ep_pkg::HS_ACK;
        end else begin
            link.hs_valid <= 1'b0;
            if (link.tok_valid) begin
                cur_ep <= link.tok_ep;
                in_pkt <= 1'b1;
                bad    <= tok_stall; // R6
                wcnt   <= 7'h00;
            end else if (in_pkt) begin
                if (over) bad <= 1'b1; // R5
                if (link.dat_valid && !over && wcnt < 7'(DEPTH))
                    wcnt <= wcnt + 7'h01;
                if (link.pkt_end) begin
                    in_pkt        <= 1'b0;
                    link.hs_valid <= 1'b1;
                    if (bad || over) link.hs_code <= rx_ep_pkg::HS_STALL;
                    else if (busy_rx) link.hs_code <= rx_ep_pkg::HS_NAK;
                    else link.hs_code <= rx_ep_pkg::HS_ACK;
                end
            end
        end
    end

    wire stall_end = in_pkt && link.pkt_end && (bad || over);
    // A repeated data PID is acknowledged but its data is dropped.
    wire good_end  = in_pkt && link.pkt_end && !(bad || over) && !busy_rx
                     && pid_ok; // R3

    always_ff @(posedge clk_i) begin
        if (in_pkt && link.dat_valid && !over && !busy_rx
            && wcnt < 7'(DEPTH))
            mem[cur_ep][6'(wcnt)] <= link.dat_byte;
    end

    // ****************************************
    // Endpoint registers
    // ****************************************
    for (genvar e = 0; e < 2; e++) begin : g_ep
        wire       me       = cur_ep == 1'(e);
        wire       set_rdy  = good_end && me;
        wire       flush    = csr_wr[e] && dat_i[`BIT_FLUSH]
                              && csr[e][`BIT_PKT_RDY]; // R8
        wire       auto_ready_clear = fifo_rd[e] && csr[e][`BIT_AUTO_READY_CLEAR]
                              && (rptr[e] + 7'h01 >= cnt[e]); // R1
        wire       uns_clr  = csr_wr[e] && csr[e][`BIT_SEND_STALL]
                              && !dat_i[`BIT_SEND_STALL]; // R6
        wire       sw_clr   = csr_wr[e] && !dat_i[`BIT_PKT_RDY]; // R10
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                csr[e]  <= 8'h00; // R23
                max_packet_size[e] <= `MAX_PACKET_SIZE_RESET; // R11
                cnt[e]  <= 7'h00;
                tog[e]  <= 1'b0;
                rptr[e] <= 7'h00;
            end else begin
                if (csr_wr[e]) begin
                    csr[e][7:6] <= dat_i[7:6];
                    csr[e][`BIT_SEND_STALL] <= dat_i[`BIT_SEND_STALL];
                    if (!dat_i[`BIT_SENT_STALL])
                        csr[e][`BIT_SENT_STALL] <= 1'b0;
                end
                if (wr && (e == 0 ? hit_m0 : hit_m1))
                    max_packet_size[e] <= dat_i[3:0];
                if (fifo_rd[e]) rptr[e] <= rptr[e] + 7'h01;
                if (stall_end && me)
                    csr[e][`BIT_SENT_STALL] <= 1'b1; // R4
                if (csr_wr[e] && dat_i[`BIT_TOG_RST])
                    tog[e] <= 1'b0; // R3
                else if (good_end && me)
                    tog[e] <= ~tog[e];
                // A new packet wins over any clear in the same cycle.
                if (set_rdy) begin
                    csr[e][`BIT_PKT_RDY] <= 1'b1; // R9
                    cnt[e]               <= rx_len;
                    rptr[e]              <= 7'h00;
                end else if (flush || auto_ready_clear || uns_clr || sw_clr) begin
                    csr[e][`BIT_PKT_RDY] <= 1'b0; // R7
                    rptr[e]              <= 7'h00;
                end
                csr[e][`BIT_FLUSH] <= 1'b0; // R7
            end
        end
    end
    // ****************************************
    // Interrupts and DMA control
    // ****************************************
    wire rdy_a = good_end && !cur_ep;
    wire rdy_b = good_end && cur_ep;
    wire dma_done = dstate == rx_ep_pkg::DMA_MOVE && unit_left == 8'h00;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ep_irq_o  <= 2'b00;
            dma_req_o <= 1'b0;
            dctl      <= 8'h00; // R23
            unit_val  <= 8'h00; // R19
            dma_fifo_byte_counter  <= 8'h00;
            unit_left <= 8'h00;
            dstate    <= rx_ep_pkg::DMA_IDLE;
        end else begin
            ep_irq_o[0] <= rdy_a && (!dma_mode
                           || !csr[0][`BIT_IRQ_MASK]); // R2 R22
            ep_irq_o[1] <= rdy_b; // R22
            if (wr && hit_dc)
                dctl[3:0] <= dat_i[3:0]; // R15 R16 R17
            if (wr && hit_du) unit_val <= dat_i[7:0]; // R19
            if (wr && hit_fc) dma_fifo_byte_counter <= dat_i[7:0];
            if (rx_run_set)
                dma_fifo_byte_counter <= {1'b0, cnt[0]}; // R20
            case (dstate)
                rx_ep_pkg::DMA_IDLE: begin
                    if (dma_mode && |dctl[2:1]) begin
                        dstate    <= rx_ep_pkg::DMA_LOAD;
                        unit_left <= unit_val; // R19
                    end
                end
                rx_ep_pkg::DMA_LOAD: dstate <= rx_ep_pkg::DMA_MOVE;
                rx_ep_pkg::DMA_MOVE: begin
                    if (!(|dctl[2:1])) dstate <= rx_ep_pkg::DMA_IDLE;
                    else if (dma_done) dstate <= rx_ep_pkg::DMA_DONE;
                    else if (!dctl[`BIT_DEMAND] || dma_req_o)
                        unit_left <= unit_left - 8'h01; // R17
                end
                default: begin
                    dctl[2:1] <= 2'b00; // R16
                    dstate    <= rx_ep_pkg::DMA_IDLE;
                end
            endcase
            dma_req_o <= dstate == rx_ep_pkg::DMA_MOVE && !dma_done;
            dctl[`BIT_TX_RUN_OB] <= dctl[`BIT_TX_DMA_RUN]; // R18
            dctl[6:4] <= 3'(dstate); // R18
        end
    end
endmodule

// ---- hw/rx_ep_regs.svh ----
// Register offsets, field positions, reset values and timing counts.
`ifndef RX_EP_REGS_SVH
`define RX_EP_REGS_SVH
`define EPA_CSR_OFF     32'h1520_01a0
`define EPA_MAX_PACKET_SIZE_OFF    32'h1520_01a4
`define EPA_CNT_OFF     32'h1520_01a8
`define EPA_FIFO_OFF    32'h1520_01ac
`define EPB_CSR_OFF     32'h1520_01b0
`define EPB_MAX_PACKET_SIZE_OFF    32'h1520_01b4
`define EPB_CNT_OFF     32'h1520_01b8
`define EPB_FIFO_OFF    32'h1520_01bc
`define DMA_CTRL_OFF    32'h1520_01c0
`define DMA_UNIT_OFF    32'h1520_01c4
`define DMA_FCNT_OFF    32'h1520_01c8
`define BIT_AUTO_READY_CLEAR    7
`define BIT_IRQ_MASK    6
`define BIT_TOG_RST     5
`define BIT_SENT_STALL  4
`define BIT_SEND_STALL  3
`define BIT_FLUSH       2
`define BIT_PKT_RDY     0
`define BIT_TX_RUN_OB   7
`define BIT_DEMAND      3
`define BIT_RX_DMA_RUN  2
`define BIT_TX_DMA_RUN  1
`define BIT_DMA_MODE    0
`define MAX_PACKET_SIZE_RESET      4'h1
`define MAX_PACKET_SIZE_STEP       8
`define DMA_STEP_NS     40
`endif

// ---- hw/rx_ep_pkg.sv ----
// Link handshake codes shared by both ends, and the DMA states used by the device end.
package rx_ep_pkg;
    typedef enum logic [1:0] {
        HS_ACK,
        HS_NAK,
        HS_STALL
    } handshake_t;
    typedef enum logic [2:0] {
        DMA_IDLE,
        DMA_LOAD,
        DMA_MOVE,
        DMA_DONE
    } dma_state_t;
endpackage

// ---- hw/usb_rx_link_if.sv ----
// Packet link between the USB host side and the receive endpoint device.
`timescale 1ns/100ps
interface usb_rx_link_if;
    logic                    tok_valid;
    logic                    tok_ep;
    logic                    dat_valid;
    logic [7:0]              dat_byte;
    logic                    dat_pid1;
    logic                    pkt_end;
    logic                    hs_valid;
    rx_ep_pkg::handshake_t   hs_code;
    modport device (input tok_valid, tok_ep, dat_valid, dat_byte,
                    dat_pid1, pkt_end, output hs_valid, hs_code);
    modport host (output tok_valid, tok_ep, dat_valid, dat_byte,
                  dat_pid1, pkt_end, input hs_valid, hs_code);
endinterface

// ---- hw/usb_out_host.sv ----
// Host end: sends OUT packets on command and reports the handshake.
`timescale 1ns/100ps
module usb_out_host (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    usb_rx_link_if.host                link,
    input  wire logic                  send_i,
    input  wire logic                  ep_sel_i,
    input  wire logic                  pid1_i,
    input  wire logic [6:0]            len_i,
    input  wire logic [7:0]            first_byte_i,
    output logic                       busy_o,
    output logic                       done_o,
    output rx_ep_pkg::handshake_t      result_o
);
    // ****************************************
    // Packet sender
    // ****************************************
    typedef enum logic [1:0] {H_IDLE, H_TOK, H_DATA, H_WAIT} host_state_t;
    host_state_t state;
    logic [6:0]  left;
    logic [7:0]  value;
    wire         last = (left == 7'h01) || (left == 7'h00);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state          <= H_IDLE;
            left           <= 7'h00;
            value          <= 8'h00;
            busy_o         <= 1'b0;
            done_o         <= 1'b0;
            result_o       <= rx_ep_pkg::HS_ACK;
            link.tok_valid <= 1'b0;
            link.tok_ep    <= 1'b0;
            link.dat_valid <= 1'b0;
            link.dat_byte  <= 8'h00;
            link.dat_pid1  <= 1'b0;
            link.pkt_end   <= 1'b0;
        end else begin
            done_o         <= 1'b0;
            link.tok_valid <= 1'b0;
            link.dat_valid <= 1'b0;
            link.pkt_end   <= 1'b0;
            case (state)
                H_IDLE: begin
                    if (send_i) begin
                        state          <= H_TOK;
                        busy_o         <= 1'b1;
                        left           <= len_i;
                        value          <= first_byte_i;
                        link.tok_valid <= 1'b1;
                        link.tok_ep    <= ep_sel_i;
                        link.dat_pid1  <= pid1_i;
                    end
                end
                H_TOK: begin
                    state <= H_DATA;
                end
                H_DATA: begin
                    // A zero-length packet only sends the end marker.
                    if (left != 7'h00) begin
                        link.dat_valid <= 1'b1;
                        link.dat_byte  <= value;
                        value          <= value + 8'h01;
                        left           <= left - 7'h01;
                    end
                    if (last) begin
                        link.pkt_end <= 1'b1;
                        state        <= H_WAIT;
                    end
                end
                default: begin
                    if (link.hs_valid) begin
                        result_o <= link.hs_code;
                        done_o   <= 1'b1;
                        busy_o   <= 1'b0;
                        state    <= H_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// ---- tb/usb_rx_link_chk.sv ----
// Concurrent checks on the packet link joining the host and device ends.
`timescale 1ns/100ps
module usb_rx_link_chk (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  tok_valid,
    input  wire logic                  tok_ep,
    input  wire logic                  dat_valid,
    input  wire logic [7:0]            dat_byte,
    input  wire logic                  dat_pid1,
    input  wire logic                  pkt_end,
    input  wire logic                  hs_valid,
    input  wire rx_ep_pkg::handshake_t hs_code
);
    // The count saturates so that a runaway sender cannot wrap it to small.
    logic [7:0] nbytes;
    wire  [7:0] pkt_total = nbytes + {7'h0, dat_valid};
    always_ff @(posedge clk_i) begin
        if (rst_i || tok_valid) begin
            nbytes <= 8'h00;
        end else if (dat_valid && nbytes != 8'hff) begin
            nbytes <= pkt_total;
        end
    end
    // ****************************************
    // Link assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_hs_after_end:
        assert property (pkt_end |=> hs_valid)
        else $error("handshake missing after packet end");
    chk_hs_one_cycle:
        assert property (hs_valid |=> !hs_valid)
        else $error("handshake held longer than one cycle");
    chk_hs_has_cause:
        assert property (hs_valid |-> $past(pkt_end))
        else $error("handshake without a packet end");
    chk_oversize_stall:
        assert property (pkt_end && pkt_total > 8'h40 |=>
                         hs_valid && hs_code == rx_ep_pkg::HS_STALL)
        else $error("oversize packet not stalled");
    chk_reset_quiet:
        assert property (disable iff (1'b0) rst_i |=> !hs_valid)
        else $error("handshake driven out of reset");
    chk_tok_alone:
        assert property (tok_valid |-> !dat_valid && !pkt_end)
        else $error("token overlaps data");
    chk_tok_gap:
        assert property (tok_valid |=> !dat_valid && !tok_valid)
        else $error("data too soon after token");
    chk_wait_for_hs:
        assert property (pkt_end |=> !tok_valid [*2])
        else $error("new token before handshake");
    cov_ack: cover property (hs_valid && hs_code == rx_ep_pkg::HS_ACK);
    cov_nak: cover property (hs_valid && hs_code == rx_ep_pkg::HS_NAK);
    cov_stall: cover property (hs_valid && hs_code == rx_ep_pkg::HS_STALL);
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench joining host and device ends over the packet link.
`timescale 1ns/100ps
`include "rx_ep_regs.svh"
module testbench;
    typedef struct packed {logic [31:0] adr; logic [31:0] val;} row_t;
    localparam int LIMIT = 20000;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i, stb_i, we_i;
    logic [31:0] adr_i, dat_i, dat_o;
    logic [3:0] sel_i;
    logic ack_o, dma_req_o, send_i, ep_sel_i, pid1_i, busy_o, done_o;
    logic [1:0] ep_irq_o;
    logic [6:0] len_i;
    logic [7:0] first_byte_i;
    rx_ep_pkg::handshake_t result_o;
    int fail_count = 0, cmp_count = 0, cycles = 0, irq_a = 0, irq_b = 0;
    logic req_seen = 1'b0;
    row_t rows [10] = '{'{`EPA_CSR_OFF, 32'h0000_0000},
        '{`EPA_MAX_PACKET_SIZE_OFF, 32'h0000_0001}, '{`EPA_CNT_OFF, 32'h0000_0000},
        '{`EPB_CSR_OFF, 32'h0000_0000}, '{`EPB_MAX_PACKET_SIZE_OFF, 32'h0000_0001},
        '{`EPB_CNT_OFF, 32'h0000_0000}, '{`DMA_CTRL_OFF, 32'h0000_0000},
        '{`DMA_UNIT_OFF, 32'h0000_0000}, '{`DMA_FCNT_OFF, 32'h0000_0000},
        '{32'h1520_01d0, 32'h0000_0000}};
    usb_rx_link_if link ();
    usb_out_endpoint_dma #(.DEPTH(64)) i_usb_out_endpoint_dma (
        .clk_i(clk_i), .rst_i(rst_i), .link(link), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ep_irq_o(ep_irq_o),
        .dma_req_o(dma_req_o));
    usb_out_host i_usb_out_host (
        .clk_i(clk_i), .rst_i(rst_i), .link(link), .send_i(send_i),
        .ep_sel_i(ep_sel_i), .pid1_i(pid1_i), .len_i(len_i),
        .first_byte_i(first_byte_i), .busy_o(busy_o), .done_o(done_o),
        .result_o(result_o));
    usb_rx_link_chk i_usb_rx_link_chk (
        .clk_i(clk_i), .rst_i(rst_i), .tok_valid(link.tok_valid),
        .tok_ep(link.tok_ep), .dat_valid(link.dat_valid),
        .dat_byte(link.dat_byte), .dat_pid1(link.dat_pid1),
        .pkt_end(link.pkt_end), .hs_valid(link.hs_valid),
        .hs_code(link.hs_code));
    always #20 clk_i = ~clk_i;
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic summarize();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= wd;
        sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] unused;
        wb(1'b1, a, d, unused);
    endtask
    task automatic rd_chk(input string what, input logic [31:0] a,
                          input logic [31:0] exp);
        logic [31:0] d;
        wb(1'b0, a, 32'h0000_0000, d);
        check(what, exp, d);
    endtask
    task automatic send(input logic ep, input logic [6:0] len,
                        input logic [7:0] b0, input rx_ep_pkg::handshake_t hs);
        int n;
        n = 0;
        @(posedge clk_i);
        send_i <= 1'b1;
        ep_sel_i <= ep;
        len_i <= len;
        first_byte_i <= b0;
        @(posedge clk_i);
        send_i <= 1'b0;
        @(posedge clk_i);
        check("host busy", 32'h1, {31'h0, busy_o});
        do begin
            @(posedge clk_i);
            n++;
        end while (done_o !== 1'b1 && n < 400);
        check("host done", 32'h1, {31'h0, done_o});
        check("host idle", 32'h0, {31'h0, busy_o});
        check("handshake", {30'h0, hs}, {30'h0, result_o});
    endtask
    // Interrupt pulses, request level and the hang limit are watched here.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (ep_irq_o[0] === 1'b1) irq_a <= irq_a + 1;
        if (ep_irq_o[1] === 1'b1) irq_b <= irq_b + 1;
        if (dma_req_o === 1'b1) req_seen <= 1'b1;
        if (cycles == LIMIT) begin
            fail_count++;
            summarize();
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] d;
        int n;
        {cyc_i, stb_i, we_i, send_i, ep_sel_i, pid1_i} = 6'h00;
        {adr_i, dat_i, sel_i, len_i, first_byte_i} = '0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) rd_chk("reset value", rows[i].adr, rows[i].val);
        send(1'b0, 7'd8, 8'h5a, rx_ep_pkg::HS_ACK);
        rd_chk("ready set", `EPA_CSR_OFF, 32'h0000_0001);
        check("irq count", 32'd1, irq_a);
        rd_chk("byte count", `EPA_CNT_OFF, 32'h0000_0008);
        rd_chk("fifo byte", `EPA_FIFO_OFF, 32'h0000_005a);
        send(1'b0, 7'd4, 8'h11, rx_ep_pkg::HS_NAK);
        wr(`EPA_CSR_OFF, 32'h0000_0000);
        rd_chk("ready cleared", `EPA_CSR_OFF, 32'h0000_0000);
        send(1'b0, 7'd9, 8'h22, rx_ep_pkg::HS_STALL);
        rd_chk("stall sent", `EPA_CSR_OFF, 32'h0000_0010);
        wr(`EPA_CSR_OFF, 32'h0000_0000);
        wr(`EPA_MAX_PACKET_SIZE_OFF, 32'h0000_0008);
        rd_chk("max code", `EPA_MAX_PACKET_SIZE_OFF, 32'h0000_0008);
        pid1_i <= 1'b1;
        send(1'b0, 7'd64, 8'h01, rx_ep_pkg::HS_ACK);
        pid1_i <= 1'b0;
        rd_chk("full count", `EPA_CNT_OFF, 32'h0000_0040);
        wr(`EPA_CSR_OFF, 32'h0000_0081);
        rd_chk("first byte", `EPA_FIFO_OFF, 32'h0000_0001);
        for (n = 1; n < 64; n++) begin
            rd_chk("fifo order", `EPA_FIFO_OFF, 32'(n + 1));
        end
        rd_chk("auto clear", `EPA_CSR_OFF, 32'h0000_0080);
        send(1'b0, 7'd65, 8'h00, rx_ep_pkg::HS_STALL);
        rd_chk("oversize stall", `EPA_CSR_OFF, 32'h0000_0090);
        wr(`EPB_CSR_OFF, 32'h0000_0008);
        send(1'b1, 7'd2, 8'h33, rx_ep_pkg::HS_STALL);
        rd_chk("stall flags", `EPB_CSR_OFF, 32'h0000_0018);
        wr(`EPB_CSR_OFF, 32'h0000_0000);
        send(1'b1, 7'd2, 8'h44, rx_ep_pkg::HS_ACK);
        check("irq b count", 32'd1, irq_b);
        wr(`EPB_CSR_OFF, 32'h0000_0005);
        rd_chk("flushed", `EPB_CSR_OFF, 32'h0000_0000);
        wr(`EPB_CSR_OFF, 32'h0000_0004);
        rd_chk("idle flush", `EPB_CSR_OFF, 32'h0000_0000);
        wr(`EPA_CSR_OFF, 32'h0000_0000);
        send(1'b0, 7'd8, 8'h55, rx_ep_pkg::HS_ACK);
        wr(`DMA_CTRL_OFF, 32'h0000_0009);
        wb(1'b0, `DMA_CTRL_OFF, 32'h0000_0000, d);
        check("demand mode", 32'h0000_0009, d & 32'h0000_000f);
        wr(`DMA_UNIT_OFF, 32'h0000_0003);
        rd_chk("unit value", `DMA_UNIT_OFF, 32'h0000_0003);
        wr(`DMA_CTRL_OFF, 32'h0000_0005);
        n = 0;
        do begin
            wb(1'b0, `DMA_CTRL_OFF, 32'h0000_0000, d);
            n++;
        end while (d[2] !== 1'b0 && n < 50);
        check("run cleared", 32'h0000_0001, d & 32'h0000_000f);
        check("dma request", 32'h0000_0001, {31'h0, req_seen});
        rd_chk("fifo count", `DMA_FCNT_OFF, 32'h0000_0008);
        rd_chk("dma idle", `DMA_CTRL_OFF, 32'h0000_0001);
        // The toggle is at one here, so DATA0 is only taken after the reset.
        wr(`EPA_CSR_OFF, 32'h0000_0060);
        send(1'b0, 7'd8, 8'h66, rx_ep_pkg::HS_ACK);
        rd_chk("masked ready", `EPA_CSR_OFF, 32'h0000_0041);
        check("masked irq", 32'd3, irq_a);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("reset csr", `EPA_CSR_OFF, 32'h0000_0000);
        rd_chk("reset max", `EPA_MAX_PACKET_SIZE_OFF, 32'h0000_0001);
        rd_chk("reset dma", `DMA_CTRL_OFF, 32'h0000_0000);
        summarize();
    end
endmodule
